// ---- verilog/asp_regs.sv ----
// serial port transceiver with status, control and data registers on AHB-Lite
`timescale 1ns/1ps
`include "asp_defs.svh"

// Behaviour
// - empty flag on transfer; move only when cleared
// - status read then data write clears tx flags
// - done flag after data frames, not preamble/break
// - full flag when word reaches data register
// - status read then data read clears rx flags
// - idle flag once per reception
// - overrun keeps holding word, shift overwritten
// - noise and framing flags, no interrupt
// - framing plus overrun sets only overrun
// - parity error flag with optional interrupt
// - ninth bits stored and sent in nine-bit mode
// - low power stops prescalers after current byte
// - word length eight or nine data bits
// - wake method idle line or address mark
// - parity at top bit, checked on reception
// - even or odd parity, latched per byte
// - interrupt from enabled flags
// - one bit delay; enable pulse during a frame sends preamble
// - receiver enable starts start-bit hunt
// - mute mode, cleared by hardware on wake
// - break while set; pulse sends one break
// - data address: write tx, read rx
// - sixteen samples, majority, noise on disagreement
// - prescaler 1/3/4/13 then power-of-two dividers
module asp_regs #(
	parameter int HADDR_W = 32
) (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               rst_b,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire logic [HADDR_W-1:0] haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// serial line
	input  wire logic               rxd,
	output logic                    txd,
	output logic                    txd_oe,
	// interrupt
	output logic                    irq
);
	import asp_pkg::*;

	if (HADDR_W < 10 || HADDR_W > 32)
	begin
		$error("HADDR_W must lie between 10 and 32");
	end

	asp_state_s s;
	asp_state_s n;

	logic       run;
	logic       pre_tick;
	logic       tx_tick;
	logic       rx_tick;
	logic [3:0] nb;
	logic [7:0] idle_lim;
	logic [2:0] smp3;
	logic       maj;
	logic       nz;
	logic [8:0] wd;
	logic       msb;
	logic       ad_ok;

	function automatic logic [3:0] pre_term(input logic [1:0] sel);
		case (sel)
			2'h0:    pre_term = `ASP_PRE_T0;
			2'h1:    pre_term = `ASP_PRE_T1;
			2'h2:    pre_term = `ASP_PRE_T2;
			default: pre_term = `ASP_PRE_T3;
		endcase
	endfunction

	function automatic logic [6:0] pow_term(input logic [2:0] sel);
		pow_term = 7'h7f >> (3'h7 - sel);
	endfunction

	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	function automatic logic par9(input logic [8:0] w, input logic m);
		par9 = m ? ^w[8:0] : ^w[7:0];
	endfunction

	function automatic logic [10:0] frame_build(input logic [8:0] w, input logic m,
		input logic parity_enable, input logic podd);
		logic [8:0] v;
		v = w;
		if (parity_enable && m)
			v[8] = ^w[7:0] ^ podd;
		else if (parity_enable)
			v[7] = ^w[6:0] ^ podd;
		frame_build = m ? {1'b1, v[8:0], 1'b0} : {2'h3, v[7:0], 1'b0};
	endfunction

	always_comb
	begin
		n = s;
		smp3 = 3'h0;
		maj = 1'b0;
		nz = 1'b0;
		wd = 9'h000;
		msb = 1'b0;
		nb = s.ctl1[`ASP_C1_WL] ? `ASP_BITS_9 : `ASP_BITS_8;
		idle_lim = {nb, 4'h0};
		ad_ok = (haddr >> 10) == '0;

		// rate generation halts only between bytes
		run = !(s.ctl1[`ASP_C1_LPO] && s.tx_st != ASP_TX_FRAME && s.rx_st != ASP_RX_FRAME);
		pre_tick = run && s.pre_cnt == pre_term(s.baud[`ASP_BR_PRE_HI:`ASP_BR_PRE_LO]);
		tx_tick = pre_tick && s.txd_cnt == pow_term(s.baud[`ASP_BR_TX_HI:`ASP_BR_TX_LO]);
		rx_tick = pre_tick && s.rxd_cnt == pow_term(s.baud[`ASP_BR_RX_HI:`ASP_BR_RX_LO]);
		if (run)
		begin
			n.pre_cnt = pre_tick ? 4'h0 : s.pre_cnt + 4'h1;
			if (pre_tick)
			begin
				n.txd_cnt = tx_tick ? 7'h00 : s.txd_cnt + 7'h01;
				n.rxd_cnt = rx_tick ? 7'h00 : s.rxd_cnt + 7'h01;
			end
		end

		// receive line synchroniser
		n.rx_s1 = rxd;
		n.rx_s2 = s.rx_s1;

		// bus data phase of a write
		n.rdy = 1'b1;
		if (s.ap_v && s.ap_w)
		begin
			case (s.ap_idx)
				`ASP_IDX_DATA:
				begin
					n.tx_hold = hwdata[7:0];
					if (s.armed)
					begin
						n.st[`ASP_ST_TXE] = 1'b0;
						n.st[`ASP_ST_TXD] = 1'b0;
					end
					n.armed = 1'b0;
				end
				`ASP_IDX_BAUD:
					n.baud = hwdata[7:0];
				`ASP_IDX_CTL1:
					n.ctl1 = {s.ctl1[`ASP_C1_RX9], hwdata[6:0]};
				`ASP_IDX_CTL2:
				begin
					n.ctl2 = hwdata[7:0];
					if (s.ctl2[`ASP_C2_TE] && !hwdata[`ASP_C2_TE] && s.tx_st == ASP_TX_FRAME)
						n.te_gap = 1'b1;
					if (hwdata[`ASP_C2_TE] && s.te_gap)
					begin
						n.pend_pre = 1'b1;
						n.te_gap = 1'b0;
					end
					if (!s.ctl2[`ASP_C2_BRK] && hwdata[`ASP_C2_BRK])
						n.pend_brk = 1'b1;
				end
				default:
					n.armed = s.armed;
			endcase
		end

		// bus address phase
		n.ap_v = hsel && hready && htrans[1];
		n.ap_w = hwrite;
		n.ap_idx = ad_ok ? haddr[9:2] : `ASP_IDX_NONE;
		if (n.ap_v && !hwrite)
		begin
			case (n.ap_idx)
				`ASP_IDX_STATUS:
				begin
					n.rdata = s.st;
					n.armed = 1'b1;
				end
				`ASP_IDX_DATA:
				begin
					n.rdata = s.rx_hold;
					if (s.armed)
						n.st = n.st & `ASP_ST_KEEP_ON_RX_CLR;
					n.armed = 1'b0;
				end
				`ASP_IDX_BAUD:
					n.rdata = s.baud;
				`ASP_IDX_CTL1:
					n.rdata = s.ctl1;
				`ASP_IDX_CTL2:
					n.rdata = s.ctl2;
				default:
					n.rdata = 8'h00;
			endcase
		end

		// transmitter
		case (s.tx_st)
			ASP_TX_OFF:
				if (s.ctl2[`ASP_C2_TE])
				begin
					n.tx_st = ASP_TX_DELAY;
					n.tx_sub = 4'h0;
				end
			ASP_TX_DELAY:
				if (!s.ctl2[`ASP_C2_TE])
					n.tx_st = ASP_TX_OFF;
				else if (tx_tick)
				begin
					n.tx_sub = s.tx_sub + 4'h1;
					if (s.tx_sub == `ASP_OVS_LAST)
						n.tx_st = ASP_TX_IDLE;
				end
			ASP_TX_IDLE:
				if (!s.ctl2[`ASP_C2_TE])
				begin
					n.tx_st = ASP_TX_OFF;
					n.pend_pre = 1'b0;
				end
				else if (tx_tick)
				begin
					n.tx_bit = 4'h0;
					n.tx_sub = 4'h0;
					if (s.ctl2[`ASP_C2_BRK] || s.pend_brk)
					begin
						n.tx_kind = ASP_K_BRK;
						n.tx_sh = s.ctl1[`ASP_C1_WL] ? 11'h000 : 11'h400;
						n.pend_brk = 1'b0;
						n.tx_st = ASP_TX_FRAME;
					end
					else if (s.pend_pre)
					begin
						n.tx_kind = ASP_K_PRE;
						n.tx_sh = 11'h7ff;
						n.pend_pre = 1'b0;
						n.tx_st = ASP_TX_FRAME;
					end
					else if (!s.st[`ASP_ST_TXE])
					begin
						n.tx_kind = ASP_K_DATA;
						n.tx_sh = frame_build({s.ctl1[`ASP_C1_TX9], s.tx_hold}, s.ctl1[`ASP_C1_WL],
							s.ctl1[`ASP_C1_PCE], s.ctl1[`ASP_C1_PODD]);
						n.st[`ASP_ST_TXE] = 1'b1;
						n.tx_st = ASP_TX_FRAME;
					end
				end
			ASP_TX_FRAME:
				if (tx_tick)
				begin
					n.tx_sub = s.tx_sub + 4'h1;
					if (s.tx_sub == `ASP_OVS_LAST)
					begin
						n.tx_sh = {1'b1, s.tx_sh[10:1]};
						n.tx_bit = s.tx_bit + 4'h1;
						if (s.tx_bit == nb - 4'h1)
						begin
							n.tx_st = ASP_TX_IDLE;
							n.te_gap = 1'b0;
							if (s.tx_kind == ASP_K_DATA)
								n.st[`ASP_ST_TXD] = 1'b1;
						end
					end
				end
			default:
				n.tx_st = ASP_TX_OFF;
		endcase
		n.txd = (n.tx_st == ASP_TX_FRAME) ? n.tx_sh[0] : 1'b1;
		n.txd_oe = (n.ctl2[`ASP_C2_TE] || n.ctl2[`ASP_C2_RE] || n.tx_st == ASP_TX_FRAME)
			&& !(n.ctl1[`ASP_C1_LPO] && n.tx_st != ASP_TX_FRAME);

		// receiver
		case (s.rx_st)
			ASP_RX_OFF:
				if (s.ctl2[`ASP_C2_RE])
				begin
					n.rx_st = ASP_RX_HUNT;
					n.rx_prev = 1'b1;
					n.idle_cnt = 8'h00;
				end
			ASP_RX_HUNT:
				if (!s.ctl2[`ASP_C2_RE])
					n.rx_st = ASP_RX_OFF;
				else if (rx_tick)
				begin
					n.rx_prev = s.rx_s2;
					if (s.rx_prev && !s.rx_s2)
					begin
						n.rx_st = ASP_RX_FRAME;
						n.rx_sub = 4'h0;
						n.rx_bit = 4'h0;
						n.rx_noise = 1'b0;
						n.idle_cnt = 8'h00;
					end
					else if (!s.rx_s2)
						n.idle_cnt = 8'h00;
					else if (s.idle_cnt != idle_lim)
					begin
						n.idle_cnt = s.idle_cnt + 8'h01;
						if (n.idle_cnt == idle_lim && s.idle_arm)
						begin
							n.idle_arm = 1'b0;
							if (!s.ctl2[`ASP_C2_MUTE])
								n.st[`ASP_ST_IDLE] = 1'b1;
							else if (!s.ctl1[`ASP_C1_WAKE])
								n.ctl2[`ASP_C2_MUTE] = 1'b0;
						end
					end
				end
			ASP_RX_FRAME:
				if (!s.ctl2[`ASP_C2_RE])
					n.rx_st = ASP_RX_OFF;
				else if (rx_tick)
				begin
					n.rx_prev = s.rx_s2;
					n.rx_sub = s.rx_sub + 4'h1;
					smp3 = {s.rx_s2, s.smp[2:1]};
					if (s.rx_sub >= `ASP_SMP_FIRST && s.rx_sub <= `ASP_SMP_LAST)
						n.smp = smp3;
					if (s.rx_sub == `ASP_OVS_LAST)
						n.rx_bit = s.rx_bit + 4'h1;
					if (s.rx_sub == `ASP_SMP_LAST)
					begin
						maj = maj3(smp3);
						nz = !(&smp3 || !(|smp3));
						n.rx_noise = s.rx_noise | nz;
						if (s.rx_bit == 4'h0 && maj)
							n.rx_st = ASP_RX_HUNT;
						else if (s.rx_bit == nb - 4'h1)
						begin
							n.rx_st = ASP_RX_HUNT;
							n.idle_cnt = 8'h00;
							wd = s.ctl1[`ASP_C1_WL] ? s.rx_sh[9:1] : {1'b0, s.rx_sh[9:2]};
							msb = s.ctl1[`ASP_C1_WL] ? wd[8] : wd[7];
							if (!s.ctl2[`ASP_C2_MUTE] || (s.ctl1[`ASP_C1_WAKE] && msb))
							begin
								n.ctl2[`ASP_C2_MUTE] = 1'b0;
								if (s.st[`ASP_ST_RXF])
									n.st[`ASP_ST_OVR] = 1'b1;
								else
								begin
									n.rx_hold = wd[7:0];
									if (s.ctl1[`ASP_C1_WL])
										n.ctl1[`ASP_C1_RX9] = wd[8];
									n.st[`ASP_ST_RXF] = 1'b1;
									n.st[`ASP_ST_NSE] = n.st[`ASP_ST_NSE] | s.rx_noise | nz;
									n.st[`ASP_ST_FRM] = n.st[`ASP_ST_FRM] | !maj;
									n.st[`ASP_ST_PAR] = n.st[`ASP_ST_PAR] | (s.ctl1[`ASP_C1_PCE]
										&& (par9(wd, s.ctl1[`ASP_C1_WL]) ^ s.ctl1[`ASP_C1_PODD]));
									n.idle_arm = 1'b1;
								end
							end
						end
						else if (s.rx_bit != 4'h0)
							n.rx_sh = {maj, s.rx_sh[9:1]};
					end
				end
			default:
				n.rx_st = ASP_RX_OFF;
		endcase

		// interrupt request
		n.irq = (n.st[`ASP_ST_TXE] && n.ctl2[`ASP_C2_TXEIE])
			|| (n.st[`ASP_ST_TXD] && n.ctl2[`ASP_C2_TXDIE])
			|| ((n.st[`ASP_ST_RXF] || n.st[`ASP_ST_OVR]) && n.ctl2[`ASP_C2_RXIE])
			|| (n.st[`ASP_ST_IDLE] && n.ctl2[`ASP_C2_IDLE_IRQ_EN])
			|| (n.st[`ASP_ST_PAR] && n.ctl1[`ASP_C1_PIE]);
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '0;
			s.st <= `ASP_ST_RST;
			s.ctl1 <= `ASP_CTL1_RST;
			s.ctl2 <= `ASP_CTL2_RST;
			s.baud <= `ASP_BAUD_RST;
			s.rdy <= 1'b1;
			s.txd <= 1'b1;
			s.rx_prev <= 1'b1;
			s.rx_s1 <= 1'b1;
			s.rx_s2 <= 1'b1;
		end
		else
			s <= n;
	end

	// outputs
	assign hrdata = {24'h000000, s.rdata};
	assign hreadyout = s.rdy;
	assign hresp = 1'b0;
	assign txd = s.txd;
	assign txd_oe = s.txd_oe;
	assign irq = s.irq;
endmodule

// ---- verilog/asp_defs.svh ----
// register map, field positions, reset values and timing counts of the serial port
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// register indices, byte address is four times the index
`define ASP_IDX_STATUS 8'h20
`define ASP_IDX_DATA   8'h21
`define ASP_IDX_BAUD   8'h22
`define ASP_IDX_CTL1   8'h23
`define ASP_IDX_CTL2   8'h24
`define ASP_IDX_NONE   8'h00

// reset values
`define ASP_ST_RST   8'hc0
`define ASP_CTL1_RST 8'h00
`define ASP_CTL2_RST 8'h00
`define ASP_BAUD_RST 8'h00

// status bits
`define ASP_ST_TXE  7
`define ASP_ST_TXD  6
`define ASP_ST_RXF  5
`define ASP_ST_IDLE 4
`define ASP_ST_OVR  3
`define ASP_ST_NSE  2
`define ASP_ST_FRM  1
`define ASP_ST_PAR  0
`define ASP_ST_KEEP_ON_RX_CLR 8'hc0

// control one bits
`define ASP_C1_RX9  7
`define ASP_C1_TX9  6
`define ASP_C1_LPO  5
`define ASP_C1_WL   4
`define ASP_C1_WAKE 3
`define ASP_C1_PCE  2
`define ASP_C1_PODD 1
`define ASP_C1_PIE  0

// control two bits
`define ASP_C2_TXEIE 7
`define ASP_C2_TXDIE 6
`define ASP_C2_RXIE  5
`define ASP_C2_IDLE_IRQ_EN  4
`define ASP_C2_TE    3
`define ASP_C2_RE    2
`define ASP_C2_MUTE  1
`define ASP_C2_BRK   0

// baud fields
`define ASP_BR_PRE_HI 7
`define ASP_BR_PRE_LO 6
`define ASP_BR_TX_HI  5
`define ASP_BR_TX_LO  3
`define ASP_BR_RX_HI  2
`define ASP_BR_RX_LO  0

// prescaler terminal counts for divide by 1, 3, 4, 13
`define ASP_PRE_T0 4'h0
`define ASP_PRE_T1 4'h2
`define ASP_PRE_T2 4'h3
`define ASP_PRE_T3 4'hc

// sixteen samples a bit, majority of samples 8, 9, 10
`define ASP_OVS_LAST  4'hf
`define ASP_SMP_FIRST 4'h7
`define ASP_SMP_LAST  4'h9

// frame lengths in bits
`define ASP_BITS_8 4'ha
`define ASP_BITS_9 4'hb

`endif

// ---- verilog/asp_pkg.sv ----
// types of the serial port
package asp_pkg;

	typedef enum logic [1:0] {ASP_TX_OFF, ASP_TX_DELAY, ASP_TX_IDLE, ASP_TX_FRAME} asp_tx_e;
	typedef enum logic [1:0] {ASP_K_DATA, ASP_K_PRE, ASP_K_BRK} asp_kind_e;
	typedef enum logic [1:0] {ASP_RX_OFF, ASP_RX_HUNT, ASP_RX_FRAME} asp_rx_e;

	typedef struct packed {
		logic [7:0]  ctl1;
		logic [7:0]  ctl2;
		logic [7:0]  baud;
		logic [7:0]  st;
		logic [7:0]  tx_hold;
		logic [7:0]  rx_hold;
		logic        armed;
		logic        idle_arm;
		logic        ap_v;
		logic        ap_w;
		logic [7:0]  ap_idx;
		logic [7:0]  rdata;
		logic        rdy;
		logic [3:0]  pre_cnt;
		logic [6:0]  txd_cnt;
		logic [6:0]  rxd_cnt;
		asp_tx_e     tx_st;
		asp_kind_e   tx_kind;
		logic [10:0] tx_sh;
		logic [3:0]  tx_bit;
		logic [3:0]  tx_sub;
		logic        te_gap;
		logic        pend_pre;
		logic        pend_brk;
		logic        txd;
		logic        txd_oe;
		asp_rx_e     rx_st;
		logic [3:0]  rx_sub;
		logic [3:0]  rx_bit;
		logic [9:0]  rx_sh;
		logic [2:0]  smp;
		logic        rx_noise;
		logic        rx_prev;
		logic [7:0]  idle_cnt;
		logic        rx_s1;
		logic        rx_s2;
		logic        irq;
	} asp_state_s;

endpackage

// ---- bench/asp_regs_properties.sv ----
// assertions on the ports of the serial port block
`timescale 1ns/1ps
`include "asp_defs.svh"
module asp_regs_properties #(
	parameter int HADDR_W = 32
) (
	// clock and reset
	input wire logic               clock,
	input wire logic               rst_b,
	// ahb-lite
	input wire logic               hsel,
	input wire logic [HADDR_W-1:0] haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic [2:0]         hsize,
	input wire logic [31:0]        hwdata,
	input wire logic               hready,
	input wire logic [31:0]        hrdata,
	input wire logic               hreadyout,
	input wire logic               hresp,
	// serial line and interrupt
	input wire logic               rxd,
	input wire logic               txd,
	input wire logic               txd_oe,
	input wire logic               irq
);
	logic       wr_p;
	logic       rd_p;
	logic [7:0] idx;
	logic [7:0] c2;
	logic       parity_irq_en;
	wire        take = hsel && hready && htrans[1];
	wire        unm  = idx < `ASP_IDX_STATUS || idx > `ASP_IDX_CTL2;

	// shadow of the control bits written over the bus
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_p <= 1'b0;
			rd_p <= 1'b0;
			idx  <= 8'h00;
			c2   <= 8'h00;
			parity_irq_en  <= 1'b0;
		end
		else
		begin
			if (wr_p && idx == `ASP_IDX_CTL2)
				c2 <= hwdata[7:0];
			if (wr_p && idx == `ASP_IDX_CTL1)
				parity_irq_en <= hwdata[`ASP_C1_PIE];
			wr_p <= take && hwrite;
			rd_p <= take && !hwrite;
			idx  <= (haddr >> 10) != 0 ? `ASP_IDX_NONE : haddr[9:2];
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	sequence s_unmapped_read;
		rd_p && unm;
	endsequence
	sequence s_te_from_off;
		$rose(c2[`ASP_C2_TE]) && !$past(txd_oe);
	endsequence

	a_ready_always: assert property (hreadyout) else $error("wait state inserted");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_unmapped_zero: assert property (s_unmapped_read |-> hrdata == 32'h0) else $error("unmapped read not zero");
	a_upper_zero: assert property (rd_p |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
	a_start_holds: assert property ($fell(txd) |=> !txd [*8]) else $error("low bit too short");
	a_idle_high: assert property (!txd_oe |-> txd) else $error("idle line not high");
	a_irq_quiet: assert property ((c2[7:4] == 4'h0 && !parity_irq_en) [*3] |-> !irq) else $error("irq while disabled");
	a_te_delay: assert property (s_te_from_off |-> txd [*8]) else $error("no delay after enable");
endmodule

bind asp_regs asp_regs_properties #(.HADDR_W(HADDR_W)) u_props (.clock(clock), .rst_b(rst_b), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .irq(irq));

// ---- bench/asp_far_end.sv ----
// far-end serial transmitter and receiver on the line
`timescale 1ns/1ps
module asp_far_end (
	// clock
	input wire logic clock,
	// serial line
	input wire logic txd,
	output logic     rxd
);
	int          nbits = 10;
	int          bt    = 16;
	int          nfr   = 0;
	logic [10:0] got   = 11'h0;
	logic [10:0] sh;

	initial
		rxd = 1'b1;

	// one frame lsb first, bt clocks a bit (16 unless changed), optional glitch mid-bit
	task automatic send(input logic [10:0] f, input int n, input int g);
		for (int b = 0; b < n; b++)
			for (int s = 0; s < bt; s++)
			begin
				@(posedge clock);
				rxd <= (b == g && s == bt / 2) ? !f[b] : f[b];
			end
		@(posedge clock);
		rxd <= 1'b1;
	endtask

	// frames from the block, sampled mid-bit
	initial
		forever
		begin
			@(negedge txd);
			sh = 11'h0;
			for (int b = 0; b < nbits; b++)
			begin
				repeat (bt / 2) @(posedge clock);
				sh[b] = txd;
				repeat (bt / 2) @(posedge clock);
			end
			got = sh;
			nfr++;
		end
endmodule

// ---- bench/tb.sv ----
// self-checking bench of the serial port block
`timescale 1ns/1ps
`include "asp_defs.svh"
module tb;
	localparam logic [7:0] IST = `ASP_IDX_STATUS;
	localparam logic [7:0] IDT = `ASP_IDX_DATA;
	localparam logic [7:0] IC1 = `ASP_IDX_CTL1;
	localparam logic [7:0] IC2 = `ASP_IDX_CTL2;
	localparam logic [7:0] IBR = `ASP_IDX_BAUD;
	logic        clock;
	logic        rst_b;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        rxd;
	logic        txd;
	logic        txd_oe;
	logic        irq;
	int          errors      = 0;
	int          comparisons = 0;

	asp_regs u_dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .irq(irq));
	asp_far_end u_far (.clock(clock), .txd(txd), .rxd(rxd));

	always #2 clock = ~clock;

	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	// single ahb-lite word transfer
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {22'h0, idx, 2'h0};
		@(posedge clock);
		while (hreadyout !== 1'b1)
			@(posedge clock);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge clock);
		while (hreadyout !== 1'b1)
			@(posedge clock);
		q = hrdata[7:0];
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task automatic rdc(input string n, input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, idx, 8'h00, q);
		chk(n, {3'h0, e}, {3'h0, q});
	endtask

	task automatic wait_fr(input int n);
		int t;
		t = 0;
		while (u_far.nfr != n && t < 2000)
		begin
			@(posedge clock);
			t++;
		end
		chk("frame count", 11'(n), 11'(u_far.nfr));
	endtask

	// clear old flags, then one frame from the far end
	task automatic rx(input logic [7:0] d, input logic s, input int g);
		logic [7:0] q;
		repeat (250) @(posedge clock);
		bus(1'b0, IST, 8'h00, q);
		bus(1'b0, IDT, 8'h00, q);
		u_far.send({1'b0, s, d, 1'b0}, 10, g);
		repeat (4) @(posedge clock);
	endtask

	task automatic t_regs();
		chk("line enable", 11'h0, 11'(txd_oe));
		rdc("status", IST, `ASP_ST_RST);
		rdc("control two", IC2, 8'h00);
		wr(IST, 8'h00);
		rdc("status", IST, 8'hc0);
		rdc("unmapped", 8'h3f, 8'h00);
		$display("register test done");
	endtask

	task automatic t_tx();
		logic [7:0] q;
		logic [7:0] ie [2] = '{8'h88, 8'h48};
		wr(IC2, 8'h08);
		bus(1'b0, IDT, 8'h00, q);
		chk("line enable", 11'h1, 11'(txd_oe));
		wr(IDT, 8'h96);
		repeat (300) @(posedge clock);
		chk("frame count", 11'h0, 11'(u_far.nfr));
		rdc("status", IST, 8'hc0);
		wr(IDT, 8'ha5);
		wait_fr(1);
		chk("frame", 11'({1'b1, 8'ha5, 1'b0}), u_far.got);
		repeat (20) @(posedge clock);
		rdc("status", IST, 8'hc0);
		wr(IC1, 8'h50);
		u_far.nbits = 11;
		wr(IDT, 8'h5a);
		wait_fr(2);
		chk("nine-bit frame", {2'b11, 8'h5a, 1'b0}, u_far.got);
		repeat (20) @(posedge clock);
		u_far.nbits = 10;
		wr(IC1, 8'h00);
		wr(IC2, 8'h09);
		wr(IC2, 8'h08);
		wait_fr(3);
		chk("break", 11'h0, u_far.got);
		repeat (200) @(posedge clock);
		chk("single break", 11'h3, 11'(u_far.nfr));
		foreach (ie[i])
		begin
			wr(IC2, ie[i]);
			repeat (4) @(posedge clock);
			chk("irq", 11'h1, 11'(irq));
			wr(IC2, 8'h08);
			repeat (4) @(posedge clock);
			chk("irq", 11'h0, 11'(irq));
		end
		$display("transmit test done");
	endtask

	task automatic t_rx();
		logic [7:0] q;
		wr(IC2, 8'h04);
		rx(8'h3c, 1'b1, -1);
		rdc("status", IST, 8'he0);
		wr(IC2, 8'h24);
		repeat (4) @(posedge clock);
		chk("irq", 11'h1, 11'(irq));
		wr(IC2, 8'h04);
		rdc("data", IDT, 8'h3c);
		rdc("status", IST, 8'hc0);
		repeat (250) @(posedge clock);
		rdc("status", IST, 8'hd0);
		wr(IC2, 8'h14);
		repeat (4) @(posedge clock);
		chk("irq", 11'h1, 11'(irq));
		wr(IC2, 8'h04);
		bus(1'b0, IDT, 8'h00, q);
		repeat (400) @(posedge clock);
		rdc("status", IST, 8'hc0);
		$display("receive test done");
	endtask

	task automatic t_errs();
		rx(8'h55, 1'b1, 3);
		rdc("noise status", IST, 8'he4);
		rdc("noise data", IDT, 8'h55);
		rx(8'h81, 1'b0, -1);
		rdc("framing status", IST, 8'he2);
		rx(8'h11, 1'b1, -1);
		u_far.send({3'h0, 8'h22, 1'b0}, 10, -1);
		repeat (4) @(posedge clock);
		rdc("overrun status", IST, 8'he8);
		rdc("overrun data", IDT, 8'h11);
		$display("error test done");
	endtask

	task automatic t_parity();
		logic [7:0] c1 [2] = '{8'h05, 8'h07};
		logic [7:0] st [2] = '{8'he1, 8'he0};
		foreach (c1[i])
		begin
			wr(IC1, c1[i]);
			rx(8'h01, 1'b1, -1);
			rdc("parity status", IST, st[i]);
			chk("parity irq", 11'(st[i][0]), 11'(irq));
		end
		wr(IC1, 8'h00);
		$display("parity test done");
	endtask

	task automatic t_mute();
		wr(IC1, 8'h08);
		wr(IC2, 8'h06);
		rx(8'h12, 1'b1, -1);
		rdc("muted status", IST, 8'hc0);
		rx(8'h92, 1'b1, -1);
		rdc("woken status", IST, 8'he0);
		rdc("woken control", IC2, 8'h04);
		rdc("woken data", IDT, 8'h92);
		wr(IC1, 8'h00);
		wr(IC2, 8'h06);
		repeat (250) @(posedge clock);
		rdc("idle wake control", IC2, 8'h04);
		rdc("idle wake status", IST, 8'hc0);
		$display("mute test done");
	endtask

	task automatic t_baud();
		wr(IBR, 8'h40);
		rdc("baud", IBR, 8'h40);
		u_far.bt = 48;
		wr(IC1, 8'h00);
		wr(IC2, 8'h0c);
		rdc("baud status", IST, 8'hc0);
		wr(IDT, 8'h3e);
		wait_fr(4);
		chk("slow frame", 11'({1'b1, 8'h3e, 1'b0}), u_far.got);
		rx(8'hc3, 1'b1, -1);
		rdc("slow rx status", IST, 8'he0);
		rdc("slow rx data", IDT, 8'hc3);
		wr(IC1, 8'h20);
		repeat (4) @(posedge clock);
		chk("low power enable", 11'h0, 11'(txd_oe));
		wr(IC1, 8'h00);
		repeat (4) @(posedge clock);
		chk("line enable", 11'h1, 11'(txd_oe));
		$display("baud test done");
	endtask

	initial
	begin
		repeat (50000) @(posedge clock);
		errors++;
		end_of_test();
	end

	initial
	begin
		clock  = 1'b0;
		rst_b  = 1'b0;
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		t_regs();
		t_tx();
		t_rx();
		t_errs();
		t_parity();
		t_mute();
		t_baud();
		end_of_test();
	end
endmodule
